// [hdl/gpc_capture.v]
// gated ping-pong / segmented capture buffer with AXI4-Lite access
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "gpc_capture_regs.vh"
//
// Summary of operation
// - store only after trigger level and edge
// - gate open by duration or threshold
// - capture blocks until count or time stop
// - peak filter keeps threshold or hysteresis peaks
// - dual-bank mode writes one, host reads other
// - optional gating drops samples outside gates
// - segments filled while host drains another
// - hand segments over whole, not per sample
module gpc_capture #(
  parameter DW = 16,
  parameter NUM_SEG = 4,
  parameter SEG_W = 2,
  parameter SEG_LEN = 256,
  parameter IDX_W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // sample stream from the converter
  input wire s_valid,
  input wire [DW-1:0] s_data,
  // axi4-lite write address
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // axi4-lite read data
  input wire s_axi_rvalid_unused,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp
);
  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [7:0] ctrl_q; // mode bits, start/stop are pulses
  reg [DW-1:0] trig_level_q; // trigger level
  reg [31:0] gate_len_q; // gate duration in samples
  reg [DW-1:0] gate_thresh_q; // gate hold threshold
  reg [DW-1:0] peak_thresh_q; // peak filter threshold
  reg [DW-1:0] peak_hyst_q; // peak filter hysteresis
  reg [31:0] block_limit_q; // blocks to capture, 0 = no limit
  reg [31:0] time_limit_q; // microseconds, 0 = no limit
  // capture state
  reg run_q; // capture session in progress
  reg done_q; // session ended by stop condition
  reg overrun_q; // sticky overrun
  reg [31:0] block_cnt_q; // completed blocks
  reg [31:0] time_cnt_q; // elapsed microseconds
  reg [4:0] tick_div_q; // microsecond divider
  reg [NUM_SEG-1:0] full_q; // segment holds unread data
  reg [SEG_W-1:0] wseg_q; // segment being filled
  reg [IDX_W-1:0] widx_q; // write index inside segment
  reg [SEG_W-1:0] rseg_q; // segment being drained
  reg [IDX_W-1:0] ridx_q; // read index inside segment
  reg [DW-1:0] mem [0:NUM_SEG*SEG_LEN-1]; // sample storage
  // bus state
  reg aw_held_q; // write address taken
  reg w_held_q; // write data taken
  reg [7:0] waddr_q; // latched write address
  reg [31:0] wdata_q; // latched write data
  reg [3:0] wstrb_q; // latched byte enables
  ////////////////////////////////////////////////////////////////////////
  // gate and filter pipeline
  wire k_valid;
  wire [DW-1:0] k_data;
  wire f_valid;
  wire [DW-1:0] f_data;
  gpc_trigger_gate #(.DW(DW)) u_gate (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(run_q && !start_p),
    .falling(ctrl_q[`GPC_CTRL_FALLING]),
    .gate_thr_mode(ctrl_q[`GPC_CTRL_GATE_THR]),
    .gating_en(ctrl_q[`GPC_CTRL_GATING_EN]),
    .trig_level(trig_level_q),
    .gate_len(gate_len_q),
    .gate_thresh(gate_thresh_q),
    .s_valid(s_valid),
    .s_data(s_data),
    .k_valid_q(k_valid),
    .k_data_q(k_data)
  );
  gpc_peak_filter #(.DW(DW)) u_filt (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(run_q && !start_p),
    .en(ctrl_q[`GPC_CTRL_FILT_EN]),
    .hyst_mode(ctrl_q[`GPC_CTRL_FILT_HYST]),
    .thresh(peak_thresh_q),
    .hyst(peak_hyst_q),
    .i_valid(k_valid),
    .i_data(k_data),
    .o_valid_q(f_valid),
    .o_data_q(f_data)
  );
  ////////////////////////////////////////////////////////////////////////
  // decode and helper terms
  wire seg_mode = ctrl_q[`GPC_CTRL_SEGMENTED];
  // dual-bank uses segments 0 and 1 only
  wire [SEG_W-1:0] last_seg = seg_mode ? NUM_SEG[SEG_W-1:0] - 1'b1 :
                              {{(SEG_W-1){1'b0}}, 1'b1};
  wire [SEG_W-1:0] wseg_nx = (wseg_q == last_seg) ? {SEG_W{1'b0}} :
                             wseg_q + 1'b1;
  wire [SEG_W-1:0] rseg_nx = (rseg_q == last_seg) ? {SEG_W{1'b0}} :
                             rseg_q + 1'b1;
  wire [IDX_W-1:0] idx_last = SEG_LEN[IDX_W-1:0] - 1'b1;
  wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire start_p = do_write && (waddr_q == `GPC_OFF_CTRL) &&
                 wstrb_q[0] && wdata_q[`GPC_CTRL_START];
  wire stop_p = do_write && (waddr_q == `GPC_OFF_CTRL) &&
                wstrb_q[0] && wdata_q[`GPC_CTRL_STOP];
  wire ovr_clr = do_write && (waddr_q == `GPC_OFF_STATUS) &&
                 wstrb_q[0] && wdata_q[`GPC_STAT_OVERRUN];
  wire pop = do_read && (s_axi_araddr == `GPC_OFF_READ_DATA) &&
             full_q[rseg_q];
  wire store = run_q && f_valid && !full_q[wseg_q];
  wire seg_done = store && (widx_q == idx_last);
  wire blk_stop = (block_limit_q != 32'h0) &&
                  (block_cnt_q + (seg_done ? 32'h1 : 32'h0) >=
                   block_limit_q);
  wire time_stop = (time_limit_q != 32'h0) && (time_cnt_q >= time_limit_q);
  wire tick = (tick_div_q == `GPC_TICK_CYCLES - 1);
  // byte-lane merge for narrow register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction
  localparam PW = 32 - DW; // pad to a bus word
  wire [31:0] m_ct = merge({24'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] m_tl = merge({{PW{1'b0}}, trig_level_q}, wdata_q, wstrb_q);
  wire [31:0] m_gt = merge({{PW{1'b0}}, gate_thresh_q}, wdata_q, wstrb_q);
  wire [31:0] m_pt = merge({{PW{1'b0}}, peak_thresh_q}, wdata_q, wstrb_q);
  wire [31:0] m_ph = merge({{PW{1'b0}}, peak_hyst_q}, wdata_q, wstrb_q);
  wire [31:0] status_w = {{(8-SEG_W){1'b0}}, rseg_q,
                          {(8-SEG_W){1'b0}}, wseg_q,
                          {(8-NUM_SEG){1'b0}}, full_q,
                          5'h0, overrun_q, done_q, run_q};
  ////////////////////////////////////////////////////////////////////////
  // session control and stop conditions
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      run_q <= 1'b0;
      done_q <= 1'b0;
      block_cnt_q <= 32'h0;
      time_cnt_q <= 32'h0;
      tick_div_q <= 5'h0;
    end
    else if (start_p)
    begin
      // a new session discards the old count and flags
      run_q <= 1'b1;
      done_q <= 1'b0;
      block_cnt_q <= 32'h0;
      time_cnt_q <= 32'h0;
      tick_div_q <= 5'h0;
    end
    else if (run_q)
    begin
      tick_div_q <= tick ? 5'h0 : tick_div_q + 5'h1;
      if (tick)
        time_cnt_q <= time_cnt_q + 32'h1;
      if (seg_done)
        block_cnt_q <= block_cnt_q + 32'h1;
      // keep capturing block after block until a limit hits or software writes stop
      if (blk_stop || time_stop || stop_p)
      begin
        run_q <= 1'b0;
        done_q <= !stop_p;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // segment writer; a block is one whole segment
  always @(posedge sys_clk)
  begin
    if (store)
      mem[{wseg_q, widx_q}] <= f_data;
  end
  always @(posedge sys_clk)
  begin
    if (sys_rst || start_p)
    begin
      wseg_q <= {SEG_W{1'b0}};
      widx_q <= {IDX_W{1'b0}};
    end
    else if (store)
    begin
      widx_q <= seg_done ? {IDX_W{1'b0}} : widx_q + 1'b1;
      // switch banks automatically when the block is complete
      if (seg_done)
        wseg_q <= wseg_nx;
    end
  end
  // sticky overrun: set beats the software clear
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      overrun_q <= 1'b0;
    else if (run_q && f_valid && full_q[wseg_q])
      overrun_q <= 1'b1;
    else if (ovr_clr || start_p)
      overrun_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // ownership of segments: writer hands over, reader gives back
  always @(posedge sys_clk)
  begin : own
    integer i;
    if (sys_rst || start_p)
    begin
      full_q <= {NUM_SEG{1'b0}};
      rseg_q <= {SEG_W{1'b0}};
      ridx_q <= {IDX_W{1'b0}};
    end
    else
    begin
      for (i = 0; i < NUM_SEG; i = i + 1)
      begin
        // readout sees a segment only once it is complete
        if (seg_done && wseg_q == i[SEG_W-1:0])
          full_q[i] <= 1'b1;
        else if (pop && ridx_q == idx_last && rseg_q == i[SEG_W-1:0])
          full_q[i] <= 1'b0;
      end
      if (pop)
      begin
        ridx_q <= (ridx_q == idx_last) ? {IDX_W{1'b0}} : ridx_q + 1'b1;
        if (ridx_q == idx_last)
          rseg_q <= rseg_nx;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPC_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // only writable words answer okay
        s_axi_bresp <= (waddr_q <= `GPC_OFF_STATUS) ? `GPC_RESP_OKAY :
                       `GPC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // register file updates; start and stop never stay set
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `GPC_CTRL_RST;
      trig_level_q <= {DW{1'b0}};
      gate_len_q <= 32'h0;
      gate_thresh_q <= {DW{1'b0}};
      peak_thresh_q <= {DW{1'b0}};
      peak_hyst_q <= {DW{1'b0}};
      block_limit_q <= 32'h0;
      time_limit_q <= 32'h0;
    end
    else if (do_write)
    begin
      case (waddr_q)
        `GPC_OFF_CTRL:
          ctrl_q <= m_ct[7:0] & 8'h7e;
        `GPC_OFF_TRIG_LEVEL:
          trig_level_q <= m_tl[DW-1:0];
        `GPC_OFF_GATE_LEN:
          gate_len_q <= merge(gate_len_q, wdata_q, wstrb_q);
        `GPC_OFF_GATE_THRESH:
          gate_thresh_q <= m_gt[DW-1:0];
        `GPC_OFF_PEAK_THRESH:
          peak_thresh_q <= m_pt[DW-1:0];
        `GPC_OFF_PEAK_HYST:
          peak_hyst_q <= m_ph[DW-1:0];
        `GPC_OFF_BLOCK_LIMIT:
          block_limit_q <= merge(block_limit_q, wdata_q, wstrb_q);
        `GPC_OFF_TIME_LIMIT:
          time_limit_q <= merge(time_limit_q, wdata_q, wstrb_q);
        default:
          ctrl_q <= ctrl_q;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel; a data read pops one stored word
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `GPC_RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `GPC_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `GPC_OFF_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
        `GPC_OFF_TRIG_LEVEL: s_axi_rdata <= {{PW{1'b0}}, trig_level_q};
        `GPC_OFF_GATE_LEN: s_axi_rdata <= gate_len_q;
        `GPC_OFF_GATE_THRESH: s_axi_rdata <= {{PW{1'b0}}, gate_thresh_q};
        `GPC_OFF_PEAK_THRESH: s_axi_rdata <= {{PW{1'b0}}, peak_thresh_q};
        `GPC_OFF_PEAK_HYST: s_axi_rdata <= {{PW{1'b0}}, peak_hyst_q};
        `GPC_OFF_BLOCK_LIMIT: s_axi_rdata <= block_limit_q;
        `GPC_OFF_TIME_LIMIT: s_axi_rdata <= time_limit_q;
        `GPC_OFF_STATUS: s_axi_rdata <= status_w;
        `GPC_OFF_BLOCK_CNT: s_axi_rdata <= block_cnt_q;
        // empty readout returns zero and does not advance
        `GPC_OFF_READ_DATA:
          s_axi_rdata <= full_q[rseg_q] ?
                         {{PW{1'b0}}, mem[{rseg_q, ridx_q}]} : 32'h0;
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `GPC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/gpc_capture_regs.vh]
// register offsets, field positions, reset values and timing counts
`ifndef GPC_CAPTURE_REGS_VH
`define GPC_CAPTURE_REGS_VH
// byte offsets of the register words
`define GPC_OFF_CTRL 8'h00
`define GPC_OFF_TRIG_LEVEL 8'h04
`define GPC_OFF_GATE_LEN 8'h08
`define GPC_OFF_GATE_THRESH 8'h0c
`define GPC_OFF_PEAK_THRESH 8'h10
`define GPC_OFF_PEAK_HYST 8'h14
`define GPC_OFF_BLOCK_LIMIT 8'h18
`define GPC_OFF_TIME_LIMIT 8'h1c
`define GPC_OFF_STATUS 8'h20
`define GPC_OFF_BLOCK_CNT 8'h24
`define GPC_OFF_READ_DATA 8'h28
// control field positions
`define GPC_CTRL_START 0
`define GPC_CTRL_SEGMENTED 1
`define GPC_CTRL_GATE_THR 2
`define GPC_CTRL_FALLING 3
`define GPC_CTRL_FILT_EN 4
`define GPC_CTRL_FILT_HYST 5
`define GPC_CTRL_GATING_EN 6
`define GPC_CTRL_STOP 7
// status field positions
`define GPC_STAT_BUSY 0
`define GPC_STAT_DONE 1
`define GPC_STAT_OVERRUN 2
// reset value of the control word
`define GPC_CTRL_RST 8'h40
// bus responses
`define GPC_RESP_OKAY 2'b00
`define GPC_RESP_SLVERR 2'b10
// time limit unit and clock period
`define GPC_TICK_NS 1000
`define GPC_CLK_NS 50
`define GPC_TICK_CYCLES (`GPC_TICK_NS / `GPC_CLK_NS)
`endif

// [hdl/gpc_trigger_gate.v]
// trigger detection and capture gate timing
`timescale 1ns/1ns
`default_nettype none
module gpc_trigger_gate #(
  parameter DW = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // control
  input wire run,
  input wire falling,
  input wire gate_thr_mode,
  input wire gating_en,
  input wire [DW-1:0] trig_level,
  input wire [31:0] gate_len,
  input wire [DW-1:0] gate_thresh,
  // sample stream in
  input wire s_valid,
  input wire [DW-1:0] s_data,
  // kept samples out
  output reg k_valid_q,
  output reg [DW-1:0] k_data_q
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_CLOSED = 1'b0; // waiting for trigger
  localparam ST_OPEN = 1'b1; // samples pass
  reg state_q; // gate state
  reg [DW-1:0] prev_q; // previous sample for edge detect
  reg have_prev_q; // prev_q holds a real sample
  reg [31:0] left_q; // samples left in duration mode
  wire cross_up = have_prev_q && (prev_q < trig_level) &&
                  (s_data >= trig_level);
  wire cross_dn = have_prev_q && (prev_q > trig_level) &&
                  (s_data <= trig_level);
  // both level and direction must hold
  wire trig = falling ? cross_dn : cross_up;
  ////////////////////////////////////////////////////////////////////////
  // gate state machine, one decision per sample
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_CLOSED;
      prev_q <= {DW{1'b0}};
      have_prev_q <= 1'b0;
      left_q <= 32'h0;
      k_valid_q <= 1'b0;
      k_data_q <= {DW{1'b0}};
    end
    else
    begin
      k_valid_q <= 1'b0;
      if (!run)
      begin
        // stopped: forget history so a stale edge cannot fire
        state_q <= ST_CLOSED;
        have_prev_q <= 1'b0;
      end
      else if (s_valid)
      begin
        prev_q <= s_data;
        have_prev_q <= 1'b1;
        k_data_q <= s_data;
        case (state_q)
          ST_CLOSED:
          begin
            if (trig)
            begin
              // storing begins with the triggering sample
              k_valid_q <= 1'b1;
              state_q <= ST_OPEN;
              left_q <= (gate_len == 32'h0) ? 32'h0 : gate_len - 32'h1;
              if (!gate_thr_mode && gate_len <= 32'h1 && gating_en)
                state_q <= ST_CLOSED;
            end
          end
          ST_OPEN:
          begin
            if (!gating_en)
              // no gating: stream everything after first trigger
              k_valid_q <= 1'b1;
            else if (gate_thr_mode)
            begin
              // open while the signal stays at or above threshold
              if (s_data >= gate_thresh)
                k_valid_q <= 1'b1;
              else
                state_q <= ST_CLOSED;
            end
            else
            begin
              // open for a programmed count of samples
              k_valid_q <= 1'b1;
              left_q <= left_q - 32'h1;
              if (left_q <= 32'h1)
                state_q <= ST_CLOSED;
            end
          end
          default:
            state_q <= ST_CLOSED;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/gpc_peak_filter.v]
// threshold and hysteresis peak reduction of the kept samples
`timescale 1ns/1ns
`default_nettype none
module gpc_peak_filter #(
  parameter DW = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // control
  input wire run,
  input wire en,
  input wire hyst_mode,
  input wire [DW-1:0] thresh,
  input wire [DW-1:0] hyst,
  // samples in
  input wire i_valid,
  input wire [DW-1:0] i_data,
  // reduced samples out
  output reg o_valid_q,
  output reg [DW-1:0] o_data_q
);
  ////////////////////////////////////////////////////////////////////////
  reg armed_q; // above threshold, tracking a peak
  reg [DW-1:0] peak_q; // largest sample of the current excursion
  // drop below peak by hyst ends the excursion; guard against wrap
  wire fell = (peak_q >= hyst) ? (i_data < peak_q - hyst) : 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // one output per peak in hysteresis mode, per hit in threshold mode
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      armed_q <= 1'b0;
      peak_q <= {DW{1'b0}};
      o_valid_q <= 1'b0;
      o_data_q <= {DW{1'b0}};
    end
    else
    begin
      o_valid_q <= 1'b0;
      if (!run)
        armed_q <= 1'b0;
      else if (i_valid)
      begin
        if (!en)
        begin
          // reduction off: pass through
          o_valid_q <= 1'b1;
          o_data_q <= i_data;
        end
        else if (!hyst_mode)
        begin
          // only points above threshold survive
          o_valid_q <= (i_data > thresh);
          o_data_q <= i_data;
        end
        else if (!armed_q)
        begin
          if (i_data > thresh)
          begin
            armed_q <= 1'b1;
            peak_q <= i_data;
          end
        end
        else if (fell)
        begin
          // report the located peak, discard the rest
          o_valid_q <= 1'b1;
          o_data_q <= peak_q;
          armed_q <= 1'b0;
        end
        else if (i_data > peak_q)
          peak_q <= i_data;
      end
    end
  end
endmodule
`default_nettype wire

// [test/gpc_host_model.sv]
// host model: bus master that configures and drains the capture
`timescale 1ns/1ns
`default_nettype none
module gpc_host_model (
  // clock and readout stall
  input wire logic clk,
  input wire logic [1:0] slow,
  // write channels
  output logic awv,
  input wire logic awr,
  output logic [7:0] aw,
  output logic wv,
  input wire logic wrdy,
  output logic [31:0] wd,
  input wire logic bv,
  output logic br,
  // read channels
  output logic arv,
  input wire logic arr,
  output logic [7:0] ar,
  input wire logic rv,
  output logic rr
);
  // idle bus at time zero
  initial
  begin
    {awv, wv, br, arv, rr, aw, wd, ar} = '0;
  end

  // one write; each channel released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awv, wv, br, aw, wd} <= {3'b111, a, d};
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end
    while (!bv);
    br <= 1'b0;
  endtask

  // one read; slow drains hold rready back, as a busy host would
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {arv, ar} <= {1'b1, a};
    do
      @(posedge clk);
    while (!arr);
    arv <= 1'b0;
    repeat (slow)
      @(posedge clk);
    rr <= 1'b1;
    do
      @(posedge clk);
    while (!rv);
    rr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/gpc_capture_checker.sv]
// bus handshake assertions for the capture block
`timescale 1ns/1ns
`default_nettype none
module gpc_capture_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus ports watched
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_read_next: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_single: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_write_single: assert property (
    s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("second write taken");
  a_write_reopen: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write side not reopened");
  a_read_reopen: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read side not reopened");
  a_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2b
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind gpc_capture gpc_capture_checker u_chk (.sys_clk, .sys_rst,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// [test/gpc_capture_tb.sv]
// self-checking bench for the capture block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("MISMATCH %s exp %h got %h", n, e, g); \
    end \
  end
module gpc_capture_tb;
  localparam logic [33:0] F = 34'h3_ffff_ffff;
  // clock, reset, samples
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic s_valid = 1'b0;
  logic [15:0] s_data = 16'h0000;
  logic [1:0] slow = 2'b00;
  logic [2:0] prot = 3'h0;
  logic [3:0] strb = 4'hf;
  // bus wires
  logic awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [7:0] aw, ar;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  // bookkeeping
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h34;
  logic [33:0] rq[$], mq[$];
  logic [1:0] bq[$];
  logic [15:0] kept[$];

  always #25 sys_clk = ~sys_clk;

  // short segments keep the run brief
  gpc_capture #(.SEG_LEN(8), .IDX_W(3)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_valid(s_valid),
    .s_data(s_data), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(aw), .s_axi_awprot(prot), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar),
    .s_axi_arprot(prot), .s_axi_rvalid_unused(1'b0), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp));
  gpc_host_model host (.clk(sys_clk), .slow(slow), .awv(awv), .awr(awr),
    .aw(aw), .wv(wv), .wrdy(wrdy), .wd(wd), .bv(bv), .br(br), .arv(arv),
    .arr(arr), .ar(ar), .rv(rv), .rr(rr));

  ////////////////////////////////////////////////////////////////////////
  // answers checked against the oldest note; hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (rv && rr)
    begin
      `CHK("rdata", rq[0] & mq[0], {rresp, rdat} & mq[0])
      rq.delete(0);
      mq.delete(0);
    end
    if (bv && br)
    begin
      `CHK("bresp", bq[0], bresp)
      bq.delete(0);
    end
    if (cyc == 20000)
    begin
      err_count++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // read with expected {resp, data} under a mask
  task automatic rdx(input logic [7:0] a, input logic [33:0] e, m);
    rq.push_back(e);
    mq.push_back(m);
    slow <= seed[1:0];
    prot <= seed[4:2];
    host.rd(a);
  endtask

  task automatic wrx(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    bq.push_back(e);
    host.wr(a, d);
  endtask

  // one sample per edge, valid held across back-to-back calls
  task automatic smp(input logic [15:0] v);
    s_valid <= 1'b1;
    s_data <= v;
    @(posedge sys_clk);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset value, unmapped read, read-only write
    rdx(8'h00, 34'h40, F);
    rdx(8'h30, 34'h2_0000_0000, F);
    wrx(8'h24, 32'h5, 2'b10);
    // narrow write lands in its own byte lane only
    strb <= 4'h2;
    wrx(8'h04, 32'hffff_abcd, 2'b00);
    strb <= 4'hf;
    rdx(8'h04, 34'hab00, F);
    $display("test 1 done");
    // rising trigger, five-sample gates, stop after one block
    wrx(8'h04, 32'h64, 2'b00);
    wrx(8'h08, 32'h5, 2'b00);
    wrx(8'h18, 32'h1, 2'b00);
    wrx(8'h00, 32'h41, 2'b00);
    rdx(8'h28, 34'h0, F);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      smp(16'(seed % 90));
    end
    for (int i = 100; i < 107; i++)
      smp(16'(i));
    smp(16'h32);
    for (int i = 110; i < 115; i++)
      smp(16'(i));
    s_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdx(8'h20, 34'h102, 34'h102);
    rdx(8'h24, 34'h1, F);
    for (int i = 0; i < 8; i++)
      rdx(8'h28, 34'(i < 5 ? 100 + i : 105 + i), F);
    $display("test 2 done");
    // falling trigger, peak filter, fill every bank then overrun
    wrx(8'h04, 32'h12c, 2'b00);
    wrx(8'h10, 32'hc8, 2'b00);
    wrx(8'h18, 32'h0, 2'b00);
    for (int m = 0; m < 2; m++)
    begin
      wrx(8'h00, 32'h19 | 32'(m << 1), 2'b00);
      kept.delete();
      smp(16'h190);
      smp(16'hfa);
      kept.push_back(16'hfa);
      while (kept.size() <= 8 * (2 + 2 * m))
      begin
        seed = xs(seed);
        smp(16'(seed[8:0]));
        if (seed[8:0] > 9'hc8)
          kept.push_back(16'(seed[8:0]));
      end
      s_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rdx(8'h20, 34'h4, 34'h4);
      for (int i = 0; i < 8 * (2 + 2 * m); i++)
        rdx(8'h28, 34'(kept[i]), F);
      wrx(8'h20, 32'h4, 2'b00);
      rdx(8'h20, 34'h0, 34'h4);
      $display("test %0d done", 3 + m);
    end
    wrx(8'h00, 32'h80, 2'b00);
    rdx(8'h20, 34'h0, 34'h3);
    $display("test 5 done");
    @(posedge sys_clk);
    close_out;
  end
endmodule
`default_nettype wire
